// File: dpr_pkg.sv
// Constants, register map and carrier types for the diagnostic pipeline register.
// Assumes a single system clock; all pin inputs are resynchronised before use.
// Summary of operation
// - Eight-bit pipeline register loads from parallel input and drives the output port.
// - Shadow register changes only on shadow clock rising edges or software shadow steps; mode and scan choose source.
// - Pipeline register changes only on pipeline clock edges or software pipeline steps; mode picks input or shadow.
// - Both clocks act independently; shift and pipeline load may coincide.
// - Mode low: shadow shifts toward msb, bit 0 from scan input, input port undriven.
// - Mode low: pipeline clock copies each parallel input bit into the pipeline register.
// - Mode high, scan low: shadow captures output port value, input port undriven.
// - Mode high: pipeline clock copies shadow register into the pipeline register.
// - Mode high, scan high: shadow holds and drives its contents onto the input port.
// - Shadow input chooses output port bit, next lower shadow bit or, in hold, its own bit.
// - Scan output is shadow msb when mode low, scan input when mode high.
// - Output port reflects pipeline register, changing only after a pipeline edge.
package dpr_pkg;
    localparam int DPR_W = 8;
    localparam int DPR_MSB = 7;
    localparam int WB_AW = 4;
    localparam logic [WB_AW-1:0] DPR_ADDR_CTRL = 4'h0;
    localparam logic [WB_AW-1:0] DPR_ADDR_STAT = 4'h4;
    localparam int CTRL_PIPE_STEP = 0;
    localparam int CTRL_SHADOW_STEP = 1;
    localparam logic [31:0] DPR_RD_ZERO = 32'h0000_0000;

    typedef struct packed {
        logic shadow_clk;
        logic pipe_clk;
        logic mode_sel;
        logic scan_in;
        logic pipe_out_enable_n;
        logic [DPR_W-1:0] parallel_in;
    } dpr_pins_t;

    typedef struct packed {
        logic [DPR_W-1:0] o;
        logic oe;
    } dpr_tri_t;
endpackage : dpr_pkg

// File: dpr_sync.sv
// Two-flop level synchroniser for a group of pin inputs.
// Assumes inputs are asynchronous to clk_sys; the first stage feeds only the second.
`timescale 1ns/100ps
module dpr_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            meta <= '0;
            sync_out <= '0;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule : dpr_sync

// File: dpr_top.sv
// Diagnostic pipeline register with shadow scan register and Wishbone status access.
// Assumes pin clocks are much slower than clk_sys; each pin edge is seen after sync.
`timescale 1ns/100ps
module dpr_top (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic shadow_clk,
    input wire logic pipe_clk,
    input wire logic mode_sel,
    input wire logic scan_in,
    input wire logic pipe_out_enable_n,
    input wire logic [7:0] parallel_in_port_i,
    output logic [7:0] parallel_in_port_o,
    output logic parallel_in_port_oe,
    output logic [7:0] pipe_out_port_o,
    output logic pipe_out_port_oe,
    output logic scan_out,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    dpr_pkg::dpr_pins_t pins_raw;
    dpr_pkg::dpr_pins_t pins_s;
    dpr_pkg::dpr_tri_t in_drive;
    logic [dpr_pkg::DPR_W-1:0] pipe;
    logic [dpr_pkg::DPR_W-1:0] shadow;
    logic [dpr_pkg::DPR_W-1:0] next_shadow;
    logic pipe_clk_q;
    logic shadow_clk_q;
    logic sw_pipe_step;
    logic sw_shadow_step;
    logic pipe_edge;
    logic shadow_edge;
    logic wb_req;

    // Address compare shared by the write strobe, the read data path and the checks
    function automatic logic dpr_adr_hit(
        input logic [dpr_pkg::WB_AW-1:0] adr,
        input logic [dpr_pkg::WB_AW-1:0] target
    );
        return adr == target;
    endfunction : dpr_adr_hit

    assign pins_raw = '{shadow_clk: shadow_clk, pipe_clk: pipe_clk, mode_sel: mode_sel,
                        scan_in: scan_in, pipe_out_enable_n: pipe_out_enable_n,
                        parallel_in: parallel_in_port_i};

    // All pins share one synchroniser so mode, scan and data line up with the clock pins
    dpr_sync #(.W($bits(dpr_pkg::dpr_pins_t))) u_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .async_in(pins_raw),
        .sync_out(pins_s)
    );

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pipe_clk_q <= 1'b0;
            shadow_clk_q <= 1'b0;
        end else begin
            pipe_clk_q <= pins_s.pipe_clk;
            shadow_clk_q <= pins_s.shadow_clk;
        end
    end

    // Software step strobes act as extra clock edges; separate edges keep clocks independent
    assign pipe_edge = (pins_s.pipe_clk & ~pipe_clk_q) | sw_pipe_step;
    assign shadow_edge = (pins_s.shadow_clk & ~shadow_clk_q) | sw_shadow_step;

    // Data registers carry no reset: contents are undefined until first clocked
    always_ff @(posedge clk_sys) begin
        if (pipe_edge) begin
            if (pins_s.mode_sel) begin
                pipe <= shadow;
            end else begin
                pipe <= pins_s.parallel_in;
            end
        end
    end

    always_comb begin
        next_shadow = shadow;
        if (!pins_s.mode_sel) begin
            next_shadow = {shadow[dpr_pkg::DPR_MSB-1:0], pins_s.scan_in};
        end else if (!pins_s.scan_in) begin
            next_shadow = pipe;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (shadow_edge) begin
            shadow <= next_shadow;
        end
    end

    assign scan_out = pins_s.mode_sel ? pins_s.scan_in : shadow[dpr_pkg::DPR_MSB];

    // Input port turns around only in the hold mode; otherwise it stays an input
    assign in_drive.oe = pins_s.mode_sel & pins_s.scan_in;
    assign in_drive.o = shadow;
    assign parallel_in_port_o = in_drive.o;
    assign parallel_in_port_oe = in_drive.oe;

    assign pipe_out_port_o = pipe;
    assign pipe_out_port_oe = ~pins_s.pipe_out_enable_n;

    // Wishbone slave: one wait state, ack drops the cycle after it is given
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sw_pipe_step <= 1'b0;
            sw_shadow_step <= 1'b0;
        end else begin
            sw_pipe_step <= 1'b0;
            sw_shadow_step <= 1'b0;
            if (wb_req && wb_we_i && dpr_adr_hit(wb_adr_i, dpr_pkg::DPR_ADDR_CTRL) && wb_sel_i[0]) begin
                sw_pipe_step <= wb_dat_i[dpr_pkg::CTRL_PIPE_STEP];
                sw_shadow_step <= wb_dat_i[dpr_pkg::CTRL_SHADOW_STEP];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wb_dat_o <= dpr_pkg::DPR_RD_ZERO;
        end else if (wb_req && !wb_we_i && dpr_adr_hit(wb_adr_i, dpr_pkg::DPR_ADDR_STAT)) begin
            wb_dat_o <= {16'h0000, shadow, pipe};
        end else begin
            wb_dat_o <= dpr_pkg::DPR_RD_ZERO;
        end
    end

    sequence seq_pipe_low;
        pipe_edge && !pins_s.mode_sel;
    endsequence

    sequence seq_shift;
        shadow_edge && !pins_s.mode_sel;
    endsequence

    sequence seq_pipe_high;
        pipe_edge && pins_s.mode_sel;
    endsequence

    sequence seq_capture;
        shadow_edge && pins_s.mode_sel && !pins_s.scan_in;
    endsequence

    sequence seq_stat_read;
        wb_req && !wb_we_i && dpr_adr_hit(wb_adr_i, dpr_pkg::DPR_ADDR_STAT);
    endsequence

    sequence seq_ctrl_write;
        wb_req && wb_we_i && dpr_adr_hit(wb_adr_i, dpr_pkg::DPR_ADDR_CTRL) && wb_sel_i[0];
    endsequence

    AST_PIPE_LOAD_INPUT: assert property (@(posedge clk_sys) disable iff (!rst_b)
        seq_pipe_low |=> pipe == $past(pins_s.parallel_in))
        else $error("pipeline did not load parallel input");

    AST_PIPE_LOAD_SHADOW: assert property (@(posedge clk_sys) disable iff (!rst_b)
        seq_pipe_high |=> pipe === $past(shadow))
        else $error("pipeline did not load shadow");

    AST_SHADOW_SHIFT: assert property (@(posedge clk_sys) disable iff (!rst_b)
        seq_shift |=> shadow === {$past(shadow[dpr_pkg::DPR_MSB-1:0]), $past(pins_s.scan_in)})
        else $error("shadow shift wrong");

    AST_SHADOW_CAPTURE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        seq_capture |=> shadow === $past(pipe))
        else $error("shadow did not capture output");

    AST_SHADOW_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_b)
        pins_s.mode_sel && pins_s.scan_in |=> shadow === $past(shadow))
        else $error("shadow changed in hold");

    AST_SCAN_OUT: assert property (@(posedge clk_sys) disable iff (!rst_b)
        scan_out === (pins_s.mode_sel ? pins_s.scan_in : shadow[dpr_pkg::DPR_MSB]))
        else $error("scan output wrong");

    AST_IN_PORT_DRIVE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        parallel_in_port_oe == (pins_s.mode_sel && pins_s.scan_in))
        else $error("input port drive wrong");

    AST_PIPE_STABLE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !pipe_edge |=> pipe === $past(pipe))
        else $error("pipeline changed without edge");

    AST_SHADOW_STABLE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !shadow_edge |=> shadow === $past(shadow))
        else $error("shadow changed without edge");

    AST_OUT_ENABLE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        pipe_out_port_oe == !pins_s.pipe_out_enable_n)
        else $error("output enable wrong");

    // Data registers may stay unknown until first loaded, so data checks use case equality, except the pipeline loads from parallel input
    AST_SHADOW_SOURCE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        shadow_edge |=> shadow === $past(pipe) || shadow === $past(shadow) ||
            shadow === {$past(shadow[dpr_pkg::DPR_MSB-1:0]), $past(pins_s.scan_in)})
        else $error("shadow took an illegal source");

    AST_SCAN_OUT_PASS: assert property (@(posedge clk_sys) disable iff (!rst_b)
        pins_s.mode_sel |-> scan_out == pins_s.scan_in)
        else $error("scan output did not pass scan input");

    AST_SCAN_OUT_MSB: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !pins_s.mode_sel |-> scan_out === shadow[dpr_pkg::DPR_MSB])
        else $error("scan output did not show shadow msb");

    AST_SHIFT_NO_DRIVE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !pins_s.mode_sel |-> !parallel_in_port_oe)
        else $error("input port driven while shifting");

    AST_CAPTURE_NO_DRIVE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        pins_s.mode_sel && !pins_s.scan_in |-> !parallel_in_port_oe)
        else $error("input port driven while capturing");

    AST_DRIVE_VALUE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        parallel_in_port_oe |-> parallel_in_port_o === shadow)
        else $error("input port does not carry shadow");

    AST_OUT_FOLLOWS_PIPE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        pipe_out_port_o === pipe)
        else $error("output port differs from pipeline");

    AST_OUT_DISABLE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        pins_s.pipe_out_enable_n |-> !pipe_out_port_oe)
        else $error("output port driven while disabled");

    AST_OE_KEEPS_PIPE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !pipe_edge && $changed(pins_s.pipe_out_enable_n) |=> pipe === $past(pipe))
        else $error("output enable disturbed pipeline");

    AST_BOTH_STEP: assert property (@(posedge clk_sys) disable iff (!rst_b)
        pipe_edge && shadow_edge && !pins_s.mode_sel |=> pipe == $past(pins_s.parallel_in) &&
            shadow === {$past(shadow[dpr_pkg::DPR_MSB-1:0]), $past(pins_s.scan_in)})
        else $error("simultaneous steps interfered");

    AST_PIPE_EDGE_ONE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        pins_s.pipe_clk && !pipe_clk_q |=> !(pins_s.pipe_clk && !pipe_clk_q))
        else $error("pipeline clock edge seen twice");

    AST_SHADOW_EDGE_ONE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        pins_s.shadow_clk && !shadow_clk_q |=> !(pins_s.shadow_clk && !shadow_clk_q))
        else $error("shadow clock edge seen twice");

    AST_PIPE_ONLY_ON_EDGE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        pipe !== $past(pipe) |-> $past(pipe_edge))
        else $error("pipeline moved with no step");

    AST_SHADOW_ONLY_ON_EDGE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        shadow !== $past(shadow) |-> $past(shadow_edge))
        else $error("shadow moved with no step");

    // Bus checks: one ack per request, read data zero between answers
    AST_WB_ACK_PULSE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held for more than one cycle");

    AST_WB_ACK_AFTER_REQ: assert property (@(posedge clk_sys) disable iff (!rst_b)
        wb_req |=> wb_ack_o)
        else $error("request not acknowledged");

    AST_WB_DAT_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !wb_ack_o |-> wb_dat_o == dpr_pkg::DPR_RD_ZERO)
        else $error("read data not zero outside ack");

    AST_WB_STAT_READ: assert property (@(posedge clk_sys) disable iff (!rst_b)
        seq_stat_read |=> wb_dat_o === {16'h0000, $past(shadow), $past(pipe)})
        else $error("status read data wrong");

    AST_WB_OTHER_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_b)
        wb_req && (wb_we_i || !dpr_adr_hit(wb_adr_i, dpr_pkg::DPR_ADDR_STAT)) |=>
            wb_dat_o == dpr_pkg::DPR_RD_ZERO)
        else $error("non-status access returned data");

    AST_CTRL_PIPE_STEP: assert property (@(posedge clk_sys) disable iff (!rst_b)
        seq_ctrl_write |=> sw_pipe_step == $past(wb_dat_i[dpr_pkg::CTRL_PIPE_STEP]))
        else $error("pipeline step strobe wrong");

    AST_CTRL_SHADOW_STEP: assert property (@(posedge clk_sys) disable iff (!rst_b)
        seq_ctrl_write |=> sw_shadow_step == $past(wb_dat_i[dpr_pkg::CTRL_SHADOW_STEP]))
        else $error("shadow step strobe wrong");

    AST_STEP_NO_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !(wb_req && wb_we_i && wb_sel_i[0]) |=> !sw_pipe_step && !sw_shadow_step)
        else $error("step strobe without a write");

    AST_SW_STEP_PULSE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        sw_pipe_step || sw_shadow_step |=> !sw_pipe_step && !sw_shadow_step)
        else $error("step strobe longer than one cycle");
endmodule : dpr_top

// File: dpr_far.sv
// Far-side datapath model that drives the parallel input bus.
// Assumes the device enable is high while it drives.
`timescale 1ns/100ps
module dpr_far (
    input wire logic dev_oe,
    input wire logic [7:0] dev_d,
    input wire logic [7:0] sys_d,
    output logic [7:0] bus
);
    // Datapath lets go while the shadow drives the bus, so no contention
    assign bus = dev_oe ? dev_d : sys_d;
endmodule : dpr_far

// File: tb_top.sv
// Self-checking bench for the diagnostic pipeline register.
// Assumes slow pin clocks; each pin step spans eleven cycles.
`timescale 1ns/100ps
module tb_top;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic shadow_clk = 1'b0, pipe_clk = 1'b0, mode_sel = 1'b0, scan_in = 1'b0;
    logic pipe_out_enable_n = 1'b0, cyc = 1'b0, we = 1'b0, pin_oe, po_oe, so, ack;
    logic [7:0] sys_d = 8'h00;
    logic [7:0] bus, pin_o, po;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, dout;
    logic [15:0] rows [4] = '{16'h0000, 16'hFFFF, 16'hA5A5, 16'h3C3C};
    int fail_count = 0, n_checks = 0;
    initial forever #20 clk_sys = ~clk_sys;
    dpr_far far (.dev_oe(pin_oe), .dev_d(pin_o), .sys_d(sys_d), .bus(bus));
    dpr_top dut (.clk_sys(clk_sys), .rst_b(rst_b), .shadow_clk(shadow_clk),
        .pipe_clk(pipe_clk), .mode_sel(mode_sel), .scan_in(scan_in),
        .pipe_out_enable_n(pipe_out_enable_n), .parallel_in_port_i(bus),
        .parallel_in_port_o(pin_o), .parallel_in_port_oe(pin_oe), .pipe_out_port_o(po),
        .pipe_out_port_oe(po_oe), .scan_out(so), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF),
        .wb_dat_o(dout), .wb_ack_o(ack));
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : print_verdict
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_sys);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_sys);
            if (ack === 1'b1) break;
        end
        rdat = dout;
        cyc <= 1'b0;
        if (i == 20) begin
            chk("wb_ack", 1, 0);
            print_verdict();
        end
    endtask : wb
    // Levels lead the pin clock by two cycles to meet sync setup
    task automatic pins(input logic m, input logic s, input logic pc, input logic dc);
        @(posedge clk_sys);
        mode_sel <= m;
        scan_in <= s;
        repeat (2) @(posedge clk_sys);
        pipe_clk <= pc;
        shadow_clk <= dc;
        repeat (4) @(posedge clk_sys);
        pipe_clk <= 1'b0;
        shadow_clk <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask : pins
    initial begin
        repeat (3) @(posedge clk_sys);
        chk("rst", 0, {ack, pin_oe});
        rst_b <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            sys_d <= rows[k][15:8];
            pins(1'b0, 1'b0, 1'b1, 1'b0);
            chk("pipe_out", rows[k][7:0], po);
            chk("pipe_oe", 1, po_oe);
        end
        sys_d <= 8'h5A;
        for (int k = 7; k >= 0; k--) begin
            pins(1'b0, k[0] ^ k[2], 1'b0, 1'b1);
            chk("in_oe", 0, pin_oe);
        end
        wb(1'b0, 4'h4, 0);
        chk("shift", 32'h0000_5A3C, rdat);
        chk("so_msb", 0, so);
        wb(1'b0, 4'h8, 0);
        chk("unmapped", 0, rdat);
        pins(1'b0, 1'b0, 1'b1, 1'b1);
        wb(1'b0, 4'h4, 0);
        chk("both", 32'h0000_B45A, rdat);
        pins(1'b1, 1'b0, 1'b1, 1'b0);
        pins(1'b0, 1'b1, 1'b0, 1'b1);
        wb(1'b0, 4'h4, 0);
        chk("swap", 32'h0000_69B4, rdat);
        pins(1'b1, 1'b0, 1'b0, 1'b1);
        wb(1'b0, 4'h4, 0);
        chk("capture", 32'h0000_B4B4, rdat);
        pins(1'b1, 1'b1, 1'b0, 1'b1);
        chk("drive", 32'h1B4, {pin_oe, pin_o});
        chk("so_pass", 1, so);
        pins(1'b1, 1'b0, 1'b0, 1'b0);
        chk("so_pass0", 0, so);
        pipe_out_enable_n <= 1'b1;
        sys_d <= 8'h11;
        pins(1'b0, 1'b0, 1'b0, 1'b0);
        chk("pipe_hiz", 0, po_oe);
        wb(1'b1, 4'h0, 32'h1);
        repeat (3) @(posedge clk_sys);
        wb(1'b0, 4'h4, 0);
        chk("ctrl_step", 32'h0000_B411, rdat);
        print_verdict();
    end
endmodule : tb_top
